// [common/adc_result_cfg.svh]
/*
 * constants of the conversion result readout: register indices,
 * field positions, reset values and timing counts.
 * assumes a 100 MHz core clock and a byte address of four times the index.
 */
`ifndef ADC_RESULT_CFG_SVH
`define ADC_RESULT_CFG_SVH

`define ADDR_W 10
`define IDX_CONV_CTRL 8'h93
`define IDX_CONV_MODE 8'h94
`define IDX_RES_HIGH 8'h96
`define IDX_RES_MID 8'h97
`define IDX_RES_LOW 8'h98
`define IDX_IRQ_STAT 8'hA0
`define IDX_IRQ_CLR 8'hA1
`define IDX_IRQ_EN 8'hA2

`define CTRL_EN_BIT 0
`define MODE_CLKSEL_BIT 7
`define MODE_OSR_LSB 4
`define MODE_RDY_BIT 0
`define IRQ_WORD_BIT 0
`define IRQ_STABLE_BIT 1
`define IRQ_BITS 2

`define RST_RES_HIGH 8'h00
`define RST_RES_MID 8'h00
`define RST_RES_LOW 8'h07
`define RST_OSR 3'h7

`define POS_FULL 24'h7F_FFFF
`define NEG_FULL 24'h80_0000

`define MCLK_HZ 100000000
`define MCLK_PERIOD_NS 10
`define CONV_CLK0_HZ 250000
`define CONV_CLK1_HZ 333000
`define CONV_DIV0 (`MCLK_HZ / `CONV_CLK0_HZ)
`define CONV_DIV1 (`MCLK_HZ / `CONV_CLK1_HZ)
`define FIRST_WORD_NS 15000
`define FIRST_WORD_CYC \
    ((`FIRST_WORD_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`define STABLE_ORD 2

`endif

// [common/adc_result_pkg.sv]
/*
 * types shared by the conversion result readout.
 * assumes adc_result_cfg.svh for all numeric constants.
 */
package adc_result_pkg;
    typedef enum logic [1:0] {
        SRC_OFF,
        SRC_SETTLE,
        SRC_RUN
    } src_state_t;
    typedef logic [23:0] conv_word_t;
endpackage : adc_result_pkg

// [rtl/conv_word_source.sv]
/*
 * word timing of the converter: first word after a short settle,
 * then one word per output period (converter clock over oversampling).
 * assumes enable and selections come from registers on the same clock.
 */
`timescale 1ns/1ps
`include "adc_result_cfg.svh"

module conv_word_source
    import adc_result_pkg::*;
#(
    parameter int DIV0 = `CONV_DIV0,
    parameter int DIV1 = `CONV_DIV1,
    parameter int FIRST_CYC = `FIRST_WORD_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_en,
    input wire logic i_clk_sel,
    input wire logic [2:0] i_osr,
    output logic o_word_stb
);
    src_state_t state_ff;
    src_state_t nxt_state;
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    logic [15:0] div_ff;
    logic [15:0] osr_ff;
    logic stb_ff;
    wire [15:0] div_last;
    wire [15:0] osr_last;
    wire tick;
    wire settle_done;
    wire word_due;

    function automatic logic [15:0] osr_max(input logic [2:0] sel);
        logic [3:0] sh;
        sh = 4'h0;
        case (sel)
            3'h0: sh = 4'h6;
            3'h1: sh = 4'h7;
            3'h2: sh = 4'h8;
            3'h3: sh = 4'hA;
            3'h4: sh = 4'hC;
            3'h5: sh = 4'hD;
            3'h6: sh = 4'hE;
            default: sh = 4'hF;
        endcase
        osr_max = 16'(32'(1) << sh) - 16'h0001;
    endfunction : osr_max

    assign div_last = i_clk_sel ? 16'(DIV1 - 1) : 16'(DIV0 - 1);
    assign osr_last = osr_max(i_osr);
    // no overrun when selection shrinks
    assign tick = (state_ff == SRC_RUN) && (div_ff >= div_last);
    assign settle_done = (state_ff == SRC_SETTLE) &&
        (cnt_ff == 16'(FIRST_CYC - 1));
    assign word_due = settle_done || (tick && osr_ff >= osr_last);

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            SRC_OFF: begin
                nxt_cnt = 16'h0000;
                if (i_en) begin
                    nxt_state = SRC_SETTLE;
                end
            end
            SRC_SETTLE: begin
                nxt_cnt = cnt_ff + 16'h0001;
                if (settle_done) begin
                    nxt_state = SRC_RUN;
                end
            end
            SRC_RUN: begin
                nxt_cnt = 16'h0000;
            end
            default: begin
                nxt_state = SRC_OFF;
            end
        endcase
        if (!i_en) begin
            nxt_state = SRC_OFF;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= SRC_OFF;
            cnt_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            div_ff <= 16'h0000;
            osr_ff <= 16'h0000;
        end else if (state_ff != SRC_RUN) begin
            div_ff <= 16'h0000;
            osr_ff <= 16'h0000;
        end else if (tick) begin
            div_ff <= 16'h0000;
            osr_ff <= (osr_ff >= osr_last) ? 16'h0000 : osr_ff + 16'h0001;
        end else begin
            div_ff <= div_ff + 16'h0001;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stb_ff <= 1'b0;
        end else begin
            stb_ff <= i_en && word_due;
        end
    end

    assign o_word_stb = stb_ff;
endmodule : conv_word_source

// [rtl/adc_result_readout.sv]
/*
 * conversion result readout: result bytes, ready flag, enable and
 * mode register, interrupt status, and wake pulse.
 * assumes the decimator output is on the core clock and a plain
 * register port whose read data stand one cycle after the strobe.
 */
`timescale 1ns/1ps
`include "adc_result_cfg.svh"

module adc_result_readout
    import adc_result_pkg::*;
#(
    parameter int FILT_W = 28,
    parameter int DIV0 = `CONV_DIV0,
    parameter int DIV1 = `CONV_DIV1,
    parameter int FIRST_CYC = `FIRST_WORD_CYC
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [`ADDR_W-1:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [FILT_W-1:0] i_filt_data,
    output logic [7:0] o_rd_data,
    output logic o_conv_en,
    output logic o_irq,
    output logic o_wake
);
    logic en_ff;
    logic clk_sel_ff;
    logic [2:0] osr_ff;
    logic rdy_ff;
    logic nxt_rdy;
    logic [7:0] res_high_ff;
    logic [7:0] res_mid_ff;
    logic [7:0] res_low_ff;
    logic [1:0] ord_ff;
    logic [`IRQ_BITS-1:0] stat_ff;
    logic [`IRQ_BITS-1:0] nxt_stat;
    logic [`IRQ_BITS-1:0] irq_en_ff;
    logic [7:0] rd_data_ff;
    logic irq_ff;
    logic wake_ff;
    wire word_stb;
    wire [7:0] idx;
    wire aligned;
    wire sel_ctrl;
    wire sel_mode;
    wire sel_high;
    wire sel_mid;
    wire sel_low;
    wire sel_stat;
    wire sel_clr;
    wire sel_ien;
    wire wr_ctrl;
    wire wr_mode;
    wire wr_clr;
    wire wr_ien;
    wire rdy_clear;
    wire in_range;
    conv_word_t sat_word;
    wire [`IRQ_BITS-1:0] ev;
    wire [7:0] mode_rd;
    wire [7:0] rd_mux;

    conv_word_source #(
        .DIV0(DIV0),
        .DIV1(DIV1),
        .FIRST_CYC(FIRST_CYC)
    ) u_src (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_en(en_ff),
        .i_clk_sel(clk_sel_ff),
        .i_osr(osr_ff),
        .o_word_stb(word_stb)
    );

    // address decode
    assign idx = i_addr[`ADDR_W-1:2];
    assign aligned = (i_addr[1:0] == 2'b00);
    assign sel_ctrl = aligned && (idx == `IDX_CONV_CTRL);
    assign sel_mode = aligned && (idx == `IDX_CONV_MODE);
    assign sel_high = aligned && (idx == `IDX_RES_HIGH);
    assign sel_mid = aligned && (idx == `IDX_RES_MID);
    assign sel_low = aligned && (idx == `IDX_RES_LOW);
    assign sel_stat = aligned && (idx == `IDX_IRQ_STAT);
    assign sel_clr = aligned && (idx == `IDX_IRQ_CLR);
    assign sel_ien = aligned && (idx == `IDX_IRQ_EN);
    assign wr_ctrl = i_wr && sel_ctrl;
    assign wr_mode = i_wr && sel_mode;
    assign wr_clr = i_wr && sel_clr;
    assign wr_ien = i_wr && sel_ien;

    assign in_range = (&i_filt_data[FILT_W-1:23]) ||
        !(|i_filt_data[FILT_W-1:23]);
    assign sat_word = in_range ? i_filt_data[23:0] :
        (i_filt_data[FILT_W-1] ? `NEG_FULL : `POS_FULL);

    assign rdy_clear = wr_mode && !i_wr_data[`MODE_RDY_BIT];
    assign nxt_rdy = word_stb ? 1'b1 : (rdy_clear ? 1'b0 : rdy_ff);

    assign ev = {word_stb && (ord_ff == 2'(`STABLE_ORD)), word_stb};
    assign nxt_stat = ev | (stat_ff & ~(wr_clr ?
        i_wr_data[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}}));

    assign mode_rd = {clk_sel_ff, osr_ff, 3'b000, rdy_ff};
    assign rd_mux = sel_high ? res_high_ff :
        sel_mid ? res_mid_ff :
        sel_low ? res_low_ff :
        sel_ctrl ? {7'h00, en_ff} :
        sel_mode ? mode_rd :
        sel_stat ? {{(8-`IRQ_BITS){1'b0}}, stat_ff} :
        sel_ien ? {{(8-`IRQ_BITS){1'b0}}, irq_en_ff} : 8'h00;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            en_ff <= 1'b0;
        end else if (wr_ctrl) begin
            en_ff <= i_wr_data[`CTRL_EN_BIT];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            clk_sel_ff <= 1'b0;
            osr_ff <= `RST_OSR;
        end else if (wr_mode) begin
            clk_sel_ff <= i_wr_data[`MODE_CLKSEL_BIT];
            osr_ff <= i_wr_data[`MODE_OSR_LSB+2:`MODE_OSR_LSB];
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            res_high_ff <= `RST_RES_HIGH;
            res_mid_ff <= `RST_RES_MID;
            res_low_ff <= `RST_RES_LOW;
            rdy_ff <= 1'b0;
        end else begin
            if (word_stb) begin
                res_high_ff <= sat_word[23:16];
                res_mid_ff <= sat_word[15:8];
                res_low_ff <= sat_word[7:0];
            end
            rdy_ff <= nxt_rdy;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ord_ff <= 2'b00;
        end else if (!en_ff) begin
            ord_ff <= 2'b00;
        end else if (word_stb && ord_ff != 2'(`STABLE_ORD)) begin
            ord_ff <= ord_ff + 2'b01;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            stat_ff <= {`IRQ_BITS{1'b0}};
            irq_en_ff <= {`IRQ_BITS{1'b0}};
            irq_ff <= 1'b0;
        end else begin
            stat_ff <= nxt_stat;
            if (wr_ien) begin
                irq_en_ff <= i_wr_data[`IRQ_BITS-1:0];
            end
            irq_ff <= |(stat_ff & irq_en_ff);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= word_stb;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            rd_data_ff <= 8'h00;
        end else begin
            rd_data_ff <= i_rd ? rd_mux : 8'h00;
        end
    end

    assign o_rd_data = rd_data_ff;
    assign o_conv_en = en_ff;
    assign o_irq = irq_ff;
    assign o_wake = wake_ff;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    a_ready_on_load: assert property (
        word_stb |=> rdy_ff)
        else $error("ready flag not set by new word");
    a_ready_sticky: assert property (
        rdy_ff && !rdy_clear |=> rdy_ff)
        else $error("ready flag dropped without clear");
    a_bytes_hold: assert property (
        !word_stb |=> $stable({res_high_ff, res_mid_ff, res_low_ff}))
        else $error("result bytes changed without a word");
    a_bytes_word: assert property (
        word_stb |=> {res_high_ff, res_mid_ff, res_low_ff}
            == $past(sat_word))
        else $error("result bytes differ from loaded word");
    a_sign_bit: assert property (
        word_stb |=> res_high_ff[7] == $past(i_filt_data[FILT_W-1]))
        else $error("sign bit does not follow word sign");
    a_sat_pos: assert property (
        word_stb && !in_range && !i_filt_data[FILT_W-1]
            |=> {res_high_ff, res_mid_ff, res_low_ff[7:4]} == 20'h7_FFFF)
        else $error("positive overflow not clamped");
    a_sat_neg: assert property (
        word_stb && !in_range && i_filt_data[FILT_W-1]
            |=> {res_high_ff, res_mid_ff, res_low_ff[7:4]} == 20'h8_0000)
        else $error("negative overflow not clamped");
    a_off_no_word: assert property (
        !en_ff |=> !word_stb)
        else $error("word delivered while converter off");
    a_first_wait: assert property (
        $rose(en_ff) |=> !word_stb [*8])
        else $error("word too soon after enable");
    a_stable_flag: assert property (
        word_stb && ord_ff < 2'(`STABLE_ORD) |=> !stat_ff[`IRQ_STABLE_BIT]
            || $past(stat_ff[`IRQ_STABLE_BIT]))
        else $error("early word marked stable");
    a_wake_pulse: assert property (
        word_stb |=> o_wake ##1 (!o_wake || $past(word_stb)))
        else $error("wake pulse not tied to new word");
    a_irq_level: assert property (
        ##1 o_irq == $past(|(stat_ff & irq_en_ff)))
        else $error("interrupt level mismatch");

    c_ready_seen: cover property (word_stb ##1 rdy_ff);
    c_stable_word: cover property (ev[`IRQ_STABLE_BIT]);
    c_clamped: cover property (word_stb && !in_range);
    c_irq_raised: cover property ($rose(o_irq));
endmodule : adc_result_readout

// [test/fw_model.sv]
/*
 * firmware model: register port master with write and read tasks.
 * assumes the slave answers a read one cycle after the strobe.
 */
`timescale 1ns/1ps

module fw_model #(
    parameter int AW = 10
) (
    input wire logic i_mclk,
    input wire logic [7:0] i_rd_data,
    output logic [AW-1:0] o_addr,
    output logic [7:0] o_wr_data,
    output logic o_wr,
    output logic o_rd
);
    initial begin
        o_addr = '0;
        o_wr_data = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
    end

    task automatic wr(input logic [AW-1:0] a, input logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wr_data <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [AW-1:0] a, output logic [7:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1;
        d = i_rd_data;
    endtask : rd
endmodule : fw_model

// [test/adc_result_readout_tb_top.sv]
/*
 * bench of the result readout: words, ready flag, status and irq.
 * assumes shortened converter counts and the firmware model.
 */
`timescale 1ns/1ps
`include "adc_result_cfg.svh"

module adc_result_readout_tb_top;
    import adc_result_pkg::*;
    localparam int DV0 = 4;
    localparam int DV1 = 3;
    localparam int FC = 20;
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic [27:0] i_filt_data = 28'h080_0000;
    logic [9:0] i_addr;
    logic [7:0] i_wr_data;
    logic [7:0] o_rd_data;
    logic i_wr;
    logic i_rd;
    logic o_conv_en;
    logic o_irq;
    logic o_wake;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int t_last;
    int t_now;
    int n;
    int acc_got = 0;
    int acc_exp = 0;
    int nw = 0;
    logic [7:0] md = 8'h00;
    integer seed = 32'h5a78_26c2;
    logic [7:0] r;
    logic [7:0] b_h;
    logic [7:0] b_m;
    logic [7:0] b_l;

    adc_result_readout #(.FILT_W(28), .DIV0(DV0), .DIV1(DV1),
        .FIRST_CYC(FC)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr),
        .i_rd(i_rd), .i_filt_data(i_filt_data), .o_rd_data(o_rd_data),
        .o_conv_en(o_conv_en), .o_irq(o_irq), .o_wake(o_wake));

    fw_model fw_u (.i_mclk(i_mclk), .i_rd_data(o_rd_data),
        .o_addr(i_addr), .o_wr_data(i_wr_data), .o_wr(i_wr),
        .o_rd(i_rd));

    initial begin
        forever #5 i_mclk = ~i_mclk;
    end

    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            error_cnt++;
            end_of_test();
        end
    end

    function automatic logic [9:0] ad(input logic [7:0] idx);
        return {idx, 2'b00};
    endfunction : ad

    function automatic conv_word_t sat(input logic signed [27:0] v);
        if (v > 28'sh07f_ffff) return `POS_FULL;
        if (v < 28'shf80_0000) return `NEG_FULL;
        return v[23:0];
    endfunction : sat

    function automatic logic [27:0] nxt(input int i);
        case (i)
            1: return 28'hf7f_ffff;
            2: return 28'h07f_ffff;
            3: return 28'hfff_ffff;
            default: return 28'($random(seed));
        endcase
    endfunction : nxt

    function automatic int per(input logic [7:0] m);
        int f;
        case (m[6:4])
            3'h0: f = 64;
            3'h1: f = 128;
            3'h2: f = 256;
            3'h3: f = 1024;
            3'h4: f = 4096;
            3'h5: f = 8192;
            3'h6: f = 16384;
            default: f = 32768;
        endcase
        return (m[7] ? DV1 : DV0) * f;
    endfunction : per

    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [9:0] a, input logic [7:0] exp);
        fw_u.rd(a, r);
        chk({16'h0000, r}, {16'h0000, exp});
    endtask : rd_chk

    task automatic word(input int i);
        conv_word_t exp;
        int k;
        for (k = 0; k < 1200 && o_wake !== 1'b1; k++) begin
            @(posedge i_mclk);
            #1;
        end
        exp = sat(i_filt_data);
        t_now = cyc;
        chk(24'(k < 1200), 24'h00_0001);
        if (i == 0) begin
            chk(24'(t_now - t_last >= FC && t_now - t_last <= FC + 6),
                24'h00_0001);
        end else if (i != 5) begin
            chk(24'(t_now - t_last), 24'(per(md)));
        end
        t_last = t_now;
        @(posedge i_mclk);
        #1;
        chk(24'(o_irq), 24'(i != 4));
        chk(24'(o_wake), 24'h00_0000);
        rd_chk(ad(`IDX_CONV_MODE), md | 8'h01);
        rd_chk(ad(`IDX_CONV_MODE), md | 8'h01);
        if (i == 4) begin
            md = 8'h80;
        end
        fw_u.wr(ad(`IDX_CONV_MODE), md);
        fw_u.rd(ad(`IDX_RES_HIGH), b_h);
        fw_u.rd(ad(`IDX_RES_MID), b_m);
        fw_u.rd(ad(`IDX_RES_LOW), b_l);
        chk({b_h, b_m, b_l}, exp);
        chk({8'h00, b_h, b_m}, {8'h00, exp[23:8]});
        chk({6'h00, b_h, b_m, b_l[7:6]}, {6'h00, exp[23:6]});
        chk({4'h0, b_h, b_m, b_l[7:4]}, {4'h0, exp[23:4]});
        acc_got += int'($signed({b_h, b_m, b_l}));
        acc_exp += int'($signed(exp));
        nw++;
        rd_chk(ad(`IDX_IRQ_STAT), i >= 2 ? 8'h03 : 8'h01);
        fw_u.wr(ad(`IDX_IRQ_CLR), 8'h03);
        fw_u.wr(ad(`IDX_IRQ_EN), i == 3 ? 8'h00 : 8'h03);
        rd_chk(ad(`IDX_CONV_MODE), md);
        rd_chk(ad(`IDX_IRQ_STAT), 8'h00);
        chk(24'(o_irq), 24'h00_0000);
        @(posedge i_mclk);
        i_filt_data <= nxt(i + 1);
    endtask : word

    task end_of_test();
        $display("errors %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_of_test

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd_chk(ad(`IDX_RES_HIGH), `RST_RES_HIGH);
        rd_chk(ad(`IDX_RES_MID), `RST_RES_MID);
        rd_chk(ad(`IDX_RES_LOW), `RST_RES_LOW);
        rd_chk(ad(`IDX_CONV_MODE), 8'h70);
        rd_chk(ad(`IDX_CONV_CTRL), 8'h00);
        fw_u.wr(ad(`IDX_RES_HIGH), 8'hff);
        fw_u.wr(ad(`IDX_RES_LOW), 8'hf0);
        rd_chk(ad(`IDX_RES_HIGH), `RST_RES_HIGH);
        rd_chk(ad(`IDX_RES_LOW), `RST_RES_LOW);
        rd_chk(ad(`IDX_RES_HIGH) | 10'h001, 8'h00);
        fw_u.wr(ad(`IDX_CONV_MODE), 8'h00);
        fw_u.wr(ad(`IDX_IRQ_EN), 8'h03);
        repeat (50) @(posedge i_mclk);
        fw_u.wr(ad(`IDX_CONV_CTRL), 8'h01);
        #1;
        t_last = cyc;
        chk(24'(o_conv_en), 24'h00_0001);
        for (int i = 0; i < 8; i++) begin
            word(i);
        end
        fw_u.wr(ad(`IDX_CONV_CTRL), 8'h00);
        #1;
        chk(24'(o_conv_en), 24'h00_0000);
        n = 0;
        repeat (500) begin
            @(posedge i_mclk);
            #1;
            n += int'(o_wake === 1'b1);
        end
        chk(24'(n), 24'h00_0000);
        md = 8'h20;
        fw_u.wr(ad(`IDX_CONV_MODE), md);
        repeat (50) @(posedge i_mclk);
        fw_u.wr(ad(`IDX_CONV_CTRL), 8'h01);
        #1;
        t_last = cyc;
        word(0);
        word(1);
        chk(24'(acc_got / nw), 24'(acc_exp / nw));
        i_rst <= 1'b1;
        repeat (3) @(posedge i_mclk);
        i_rst <= 1'b0;
        rd_chk(ad(`IDX_RES_LOW), `RST_RES_LOW);
        rd_chk(ad(`IDX_CONV_MODE), 8'h70);
        rd_chk(ad(`IDX_CONV_CTRL), 8'h00);
        chk(24'(o_irq | o_wake), 24'h00_0000);
        end_of_test();
    end
endmodule : adc_result_readout_tb_top
